/* File: rtl/sac_ctrl.sv */
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module sac_ctrl import sac_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DW-1:0] rdata,
  input wire logic ev_start,
  input wire logic global_ie,
  input wire logic [11:0] sample_data,
  output logic analog_en,
  output logic sample_hold,
  output logic converting,
  output logic diff_mode,
  output logic [4:0] mux_pos,
  output logic [4:0] mux_neg,
  output logic busy,
  output logic irq_rdy,
  output logic irq_wcmp
);

  // ****************************************
  // reset release and input synchronisers
  // ****************************************
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic [11:0] smp_meta_ff;
  logic [11:0] smp_ff;
  logic rst_n;

  // reset asserts at once, releases after two edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  // the analog core result settles on its own timing, so it is synchronised
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      smp_meta_ff <= 12'h000;
      smp_ff <= 12'h000;
    end else begin
      smp_meta_ff <= sample_data;
      smp_ff <= smp_meta_ff;
    end
  end

  // ****************************************
  // helper functions
  // ****************************************
  // half period of the conversion clock in peripheral cycles
  function automatic logic [7:0] half_div(input logic [2:0] clock_divider_select);
    half_div = 8'h01 << clock_divider_select;
  endfunction : half_div

  // widen one raw sample into the accumulator domain
  function automatic logic signed [19:0] widen(input logic [11:0] raw, input logic diff,
                                               input logic low_res);
    logic [11:0] v;
    v = low_res ? {{2{diff & raw[11]}}, raw[11:2]} : raw;
    if (diff) begin
      widen = {{8{v[11]}}, v};
    end else begin
      widen = {8'h00, v};
    end
  endfunction : widen

  // final result: truncate large sums, optionally left adjust
  function automatic logic [15:0] format_res(input logic signed [19:0] acc,
                                             input logic [2:0] nlog, input logic ladj,
                                             input logic low_res);
    logic signed [19:0] sh;
    sh = acc;
    if (nlog > TRUNC_FREE_LOG) begin
      sh = acc >>> (nlog - TRUNC_FREE_LOG);
    end
    format_res = sh[15:0];
    if (ladj && nlog == 3'h0) begin
      format_res = low_res ? (sh[15:0] << 6) : (sh[15:0] << 4);
    end
  endfunction : format_res

  // ****************************************
  // register file
  // ****************************************
  sac_cfg_t cfg_ff, nxt_cfg;
  logic [15:0] winlt_ff, nxt_winlt;
  logic [15:0] winht_ff, nxt_winht;
  logic [15:0] res_ff, nxt_res;
  logic [15:0] rdata_ff, nxt_rdata;
  logic flg_rdy_ff, nxt_flg_rdy;
  logic flg_wcmp_ff, nxt_flg_wcmp;
  logic ev_prev_ff;
  logic start_wr;
  logic done;
  logic wcmp_hit;
  logic [15:0] done_res;

  // a start write only counts while enabled and idle
  assign start_wr = wr && addr == OFS_COMMAND && wdata[0];

  // software writes; hardware sets of the flags win over a clear
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_winlt = winlt_ff;
    nxt_winht = winht_ff;
    nxt_flg_rdy = flg_rdy_ff;
    nxt_flg_wcmp = flg_wcmp_ff;
    if (wr) begin
      unique case (addr)
        OFS_CTRLA: begin
          nxt_cfg.enable = wdata[CA_ENABLE];
          nxt_cfg.free_running_select = wdata[CA_FREE_RUNNING_SELECT];
          nxt_cfg.conversion_mode_select = wdata[CA_CONVERSION_MODE_SELECT];
          nxt_cfg.left_adjust_select = wdata[CA_LEFT_ADJUST_SELECT];
          nxt_cfg.resolution_select = wdata[CA_RESOLUTION_SELECT];
        end
        OFS_CTRLB: nxt_cfg.accumulation_count_select = wdata[2:0];
        OFS_THIRD_CONTROL_REGISTER: nxt_cfg.clock_divider_select = wdata[2:0];
        OFS_MUX: begin
          nxt_cfg.positive_input_select = wdata[4:0];
          nxt_cfg.negative_input_select = wdata[MUX_NEG_POS+4:MUX_NEG_POS];
        end
        OFS_EVENT_CONTROL_REGISTER: nxt_cfg.start_event_input_enable = wdata[0];
        OFS_INTERRUPT_CONTROL_REGISTER: begin
          nxt_cfg.ie_rdy = wdata[FLG_RDY];
          nxt_cfg.ie_wcmp = wdata[FLG_WCMP];
        end
        OFS_INTERRUPT_FLAGS_REGISTER: begin
          if (wdata[FLG_RDY]) nxt_flg_rdy = 1'b0;
          if (wdata[FLG_WCMP]) nxt_flg_wcmp = 1'b0;
        end
        OFS_WINLT: nxt_winlt = wdata;
        OFS_WINHT: nxt_winht = wdata;
        OFS_WINCTRL: nxt_cfg.wmode = wdata[2:0];
        default: ;
      endcase
    end
    if (done) begin
      nxt_flg_rdy = 1'b1;
    end
    if (done && wcmp_hit) begin
      nxt_flg_wcmp = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= CFG_RESET;
      winlt_ff <= 16'h0000;
      winht_ff <= 16'h0000;
      flg_rdy_ff <= 1'b0;
      flg_wcmp_ff <= 1'b0;
      ev_prev_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      winlt_ff <= nxt_winlt;
      winht_ff <= nxt_winht;
      flg_rdy_ff <= nxt_flg_rdy;
      flg_wcmp_ff <= nxt_flg_wcmp;
      ev_prev_ff <= ev_start;
    end
  end

  // ****************************************
  // window compare on the finished result
  // ****************************************
  logic signed [16:0] cmp_v;
  logic signed [16:0] cmp_lt;
  logic signed [16:0] cmp_ht;

  // signed compare only for differential results
  always_comb begin
    cmp_v = {cfg_ff.conversion_mode_select & done_res[15], done_res};
    cmp_lt = {cfg_ff.conversion_mode_select & winlt_ff[15], winlt_ff};
    cmp_ht = {cfg_ff.conversion_mode_select & winht_ff[15], winht_ff};
    unique case (cfg_ff.wmode)
      WM_BELOW: wcmp_hit = cmp_v < cmp_lt;
      WM_ABOVE: wcmp_hit = cmp_v > cmp_ht;
      WM_INSIDE: wcmp_hit = cmp_v >= cmp_lt && cmp_v <= cmp_ht;
      WM_OUTSIDE: wcmp_hit = cmp_v < cmp_lt || cmp_v > cmp_ht;
      default: wcmp_hit = 1'b0;
    endcase
  end

  // ****************************************
  // conversion sequencer and prescaler
  // ****************************************
  sac_state_t st_ff, nxt_st;
  logic busy_ff, nxt_busy;
  logic [7:0] psc_ff, nxt_psc;
  logic [4:0] half_ff, nxt_half;
  logic [1:0] fmt_ff, nxt_fmt;
  logic [7:0] nsmp_ff, nxt_nsmp;
  logic signed [19:0] acc_ff, nxt_acc;
  logic [4:0] pos_ff, nxt_pos;
  logic [4:0] neg_ff, nxt_neg;
  logic diff_ff, nxt_diff;
  logic ev_rise;
  logic trigger;
  logic tick;
  logic signed [19:0] acc_sum;

  assign ev_rise = ev_start && !ev_prev_ff;
  // disabled or busy converters ignore triggers
  assign trigger = cfg_ff.enable && !busy_ff
                   && (start_wr || (cfg_ff.start_event_input_enable && ev_rise));
  assign tick = psc_ff == half_div(cfg_ff.clock_divider_select) - 8'h01;
  assign acc_sum = acc_ff + widen(smp_ff, diff_ff, cfg_ff.resolution_select);
  assign done_res = format_res(acc_sum, cfg_ff.accumulation_count_select, cfg_ff.left_adjust_select, cfg_ff.resolution_select);

  // sequencing; the prescaler counts only inside sample and convert
  always_comb begin
    nxt_st = st_ff;
    nxt_busy = busy_ff;
    nxt_psc = 8'h00;
    nxt_half = half_ff;
    nxt_fmt = fmt_ff;
    nxt_nsmp = nsmp_ff;
    nxt_acc = acc_ff;
    nxt_pos = pos_ff;
    nxt_neg = neg_ff;
    nxt_diff = diff_ff;
    nxt_res = res_ff;
    done = 1'b0;
    unique case (st_ff)
      ST_IDLE: begin
        if (trigger) begin
          nxt_st = ST_STARTUP;
          nxt_busy = 1'b1;
        end
      end
      ST_STARTUP: begin
        nxt_st = ST_SAMPLE;
        nxt_acc = 20'sh00000;
        nxt_nsmp = 8'h00;
        nxt_half = 5'h00;
        nxt_pos = cfg_ff.positive_input_select;
        nxt_neg = cfg_ff.negative_input_select;
        nxt_diff = cfg_ff.conversion_mode_select;
      end
      ST_SAMPLE: begin
        nxt_psc = tick ? 8'h00 : psc_ff + 8'h01;
        if (tick) begin
          nxt_half = half_ff + 5'h01;
          if (half_ff == SAMPLE_HALVES - 5'h01) begin
            nxt_st = ST_CONVERT;
            nxt_half = 5'h00;
          end
        end
      end
      ST_CONVERT: begin
        nxt_psc = tick ? 8'h00 : psc_ff + 8'h01;
        if (tick) begin
          nxt_half = half_ff + 5'h01;
          if (half_ff == CONV_HALVES - 5'h01) begin
            nxt_st = ST_FORMAT;
            nxt_fmt = 2'h0;
          end
        end
      end
      ST_FORMAT: begin
        nxt_fmt = fmt_ff + 2'h1;
        if (fmt_ff == FORMAT_CYC - 2'h1) begin
          nxt_acc = acc_sum;
          nxt_nsmp = nsmp_ff + 8'h01;
          nxt_half = 5'h00;
          nxt_st = ST_SAMPLE;
          // full count reached: publish and either stop or run again
          if (nxt_nsmp == (8'h01 << cfg_ff.accumulation_count_select)) begin
            done = 1'b1;
            nxt_res = done_res;
            if (cfg_ff.free_running_select) begin
              nxt_st = ST_SAMPLE;
              nxt_acc = 20'sh00000;
              nxt_nsmp = 8'h00;
              nxt_pos = cfg_ff.positive_input_select;
              nxt_neg = cfg_ff.negative_input_select;
              nxt_diff = cfg_ff.conversion_mode_select;
            end else begin
              nxt_st = ST_IDLE;
              nxt_busy = 1'b0;
            end
          end
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
    // clearing enable stops everything at once
    if (!cfg_ff.enable) begin
      nxt_st = ST_IDLE;
      nxt_busy = 1'b0;
      nxt_psc = 8'h00;
      done = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_IDLE;
      busy_ff <= 1'b0;
      psc_ff <= 8'h00;
      half_ff <= 5'h00;
      fmt_ff <= 2'h0;
      nsmp_ff <= 8'h00;
      acc_ff <= 20'sh00000;
      pos_ff <= 5'h00;
      neg_ff <= 5'h00;
      diff_ff <= 1'b0;
      res_ff <= 16'h0000;
    end else begin
      st_ff <= nxt_st;
      busy_ff <= nxt_busy;
      psc_ff <= nxt_psc;
      half_ff <= nxt_half;
      fmt_ff <= nxt_fmt;
      nsmp_ff <= nxt_nsmp;
      acc_ff <= nxt_acc;
      pos_ff <= nxt_pos;
      neg_ff <= nxt_neg;
      diff_ff <= nxt_diff;
      res_ff <= nxt_res;
    end
  end

  // ****************************************
  // read port, data one cycle after the strobe
  // ****************************************
  always_comb begin
    nxt_rdata = 16'h0000;
    if (rd) begin
      unique case (addr)
        OFS_CTRLA: nxt_rdata = {11'h000, cfg_ff.resolution_select, cfg_ff.left_adjust_select, cfg_ff.conversion_mode_select,
                                cfg_ff.free_running_select, cfg_ff.enable};
        OFS_CTRLB: nxt_rdata = {13'h0000, cfg_ff.accumulation_count_select};
        OFS_THIRD_CONTROL_REGISTER: nxt_rdata = {13'h0000, cfg_ff.clock_divider_select};
        OFS_MUX: nxt_rdata = {3'h0, cfg_ff.negative_input_select, 3'h0, cfg_ff.positive_input_select};
        OFS_COMMAND: nxt_rdata = {15'h0000, busy_ff};
        OFS_EVENT_CONTROL_REGISTER: nxt_rdata = {15'h0000, cfg_ff.start_event_input_enable};
        OFS_INTERRUPT_CONTROL_REGISTER: nxt_rdata = {14'h0000, cfg_ff.ie_wcmp, cfg_ff.ie_rdy};
        OFS_INTERRUPT_FLAGS_REGISTER: nxt_rdata = {14'h0000, flg_wcmp_ff, flg_rdy_ff};
        OFS_RES: nxt_rdata = res_ff;
        OFS_WINLT: nxt_rdata = winlt_ff;
        OFS_WINHT: nxt_rdata = winht_ff;
        OFS_WINCTRL: nxt_rdata = {13'h0000, cfg_ff.wmode};
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rdata = rdata_ff;
  assign analog_en = cfg_ff.enable;
  assign sample_hold = st_ff == ST_SAMPLE;
  assign converting = st_ff == ST_CONVERT;
  assign diff_mode = diff_ff;
  assign mux_pos = pos_ff;
  assign mux_neg = neg_ff;
  assign busy = busy_ff;
  // requests need flag, local enable and the global enable together
  assign irq_rdy = flg_rdy_ff && cfg_ff.ie_rdy && global_ie;
  assign irq_wcmp = flg_wcmp_ff && cfg_ff.ie_wcmp && global_ie;

endmodule : sac_ctrl

/* File: rtl/sac_pkg.sv */
// Operation
// - writing 1 to the start bit begins a conversion; it reads 1 until done.
// - a channel change during a conversion takes effect only at the next one.
// - a finished single sample or full accumulation sets the result-ready flag.
// - the interrupt is requested only if flag, its enable and global enable are set.
// - the result-ready flag is set on completion even with its interrupt disabled.
// - with the start-event input enabled, a routed event starts a conversion unless one is already running.
// - an event starts on its rising edge, sets the start bit, which clears when done.
// - free-running mode starts each new conversion as soon as the previous completes.
// - the accumulator is cleared at the start of every accumulated conversion.
// - accumulation sums 12-bit samples, with or without truncation of the sum.
// - up to 128 consecutive samples can be summed into one result per trigger.
// - the conversion clock comes from the peripheral clock via a selectable prescaler.
// - the prescaler rests in reset when idle and restarts at every conversion start.
// - a conversion begins one cycle after its trigger, at most two cycles late.
// - the resolution setting gives a 10-bit or 12-bit result in the result register.
// - the mode bit selects single-ended against ground or differential conversion.
// - the window compare flags below, above, inside or outside a programmed window.
// - with the enable bit 0 the converter is fully inactive.
// - startup, sample 2 clocks, convert 13.5 clocks, format 2 peripheral cycles.
// - above 16 samples, low bits of the sum are dropped to fit 16 bits.
// - differential results are sign-extended two's complement; single-ended unsigned.
// - results are right-adjusted; left-adjust puts the eight top bits in the high byte (the code left-adjusts only single-sample results).
package sac_pkg;

  // ****************************************
  // register map, word addressed
  // ****************************************
  localparam int AW = 4;
  localparam int DW = 16;
  localparam logic [AW-1:0] OFS_CTRLA = 4'h0;
  localparam logic [AW-1:0] OFS_CTRLB = 4'h1;
  localparam logic [AW-1:0] OFS_THIRD_CONTROL_REGISTER = 4'h2;
  localparam logic [AW-1:0] OFS_MUX = 4'h3;
  localparam logic [AW-1:0] OFS_COMMAND = 4'h4;
  localparam logic [AW-1:0] OFS_EVENT_CONTROL_REGISTER = 4'h5;
  localparam logic [AW-1:0] OFS_INTERRUPT_CONTROL_REGISTER = 4'h6;
  localparam logic [AW-1:0] OFS_INTERRUPT_FLAGS_REGISTER = 4'h7;
  localparam logic [AW-1:0] OFS_RES = 4'h8;
  localparam logic [AW-1:0] OFS_WINLT = 4'h9;
  localparam logic [AW-1:0] OFS_WINHT = 4'hA;
  localparam logic [AW-1:0] OFS_WINCTRL = 4'hB;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CA_ENABLE = 0;
  localparam int CA_FREE_RUNNING_SELECT = 1;
  localparam int CA_CONVERSION_MODE_SELECT = 2;
  localparam int CA_LEFT_ADJUST_SELECT = 3;
  localparam int CA_RESOLUTION_SELECT = 4;
  localparam int MUX_NEG_POS = 8;
  localparam int FLG_RDY = 0;
  localparam int FLG_WCMP = 1;

  // ****************************************
  // timing, in conversion-clock half periods and peripheral cycles
  // ****************************************
  localparam logic [4:0] SAMPLE_HALVES = 5'h04;
  localparam logic [4:0] CONV_HALVES = 5'h1B;
  localparam logic [1:0] FORMAT_CYC = 2'h2;
  localparam logic [2:0] TRUNC_FREE_LOG = 3'h4;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    WM_NONE, WM_BELOW, WM_ABOVE, WM_INSIDE, WM_OUTSIDE
  } sac_wmode_t;

  typedef struct packed {
    logic enable;
    logic free_running_select;
    logic conversion_mode_select;
    logic left_adjust_select;
    logic resolution_select;
    logic [2:0] accumulation_count_select;
    logic [2:0] clock_divider_select;
    logic [4:0] positive_input_select;
    logic [4:0] negative_input_select;
    logic start_event_input_enable;
    logic ie_rdy;
    logic ie_wcmp;
    logic [2:0] wmode;
  } sac_cfg_t;

  localparam sac_cfg_t CFG_RESET = '0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_STARTUP, ST_SAMPLE, ST_CONVERT, ST_FORMAT
  } sac_state_t;

endpackage : sac_pkg

/* File: bench/sac_ctrl_props.sv */
`timescale 1ns/1ps
module sac_ctrl_props import sac_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [DW-1:0] rdata,
  input wire logic ev_start,
  input wire logic global_ie,
  input wire logic [11:0] sample_data,
  input wire logic analog_en,
  input wire logic sample_hold,
  input wire logic converting,
  input wire logic diff_mode,
  input wire logic [4:0] mux_pos,
  input wire logic [4:0] mux_neg,
  input wire logic busy,
  input wire logic irq_rdy,
  input wire logic irq_wcmp
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ****************************************
  // sequencing checks; sample length is the shortest, convert checks only 8 of its 27 cycles, prescaler at 1
  // ****************************************
  a_irq_gate: assert property (irq_rdy |-> global_ie)
    else $error("ready request without global enable");
  a_start_busy: assert property (wr && addr == OFS_COMMAND && wdata[0] && analog_en && !busy
    |=> busy) else $error("start write did not raise busy");
  a_busy_sample: assert property ($rose(busy) |-> !sample_hold ##1 sample_hold)
    else $error("sampling not one cycle after start");
  a_sample_len: assert property ($rose(sample_hold) |-> sample_hold[*4])
    else $error("sample phase too short");
  a_conv_follow: assert property ($fell(sample_hold) && analog_en |-> converting)
    else $error("convert does not follow sample");
  a_conv_len: assert property ($rose(converting) |-> converting[*8])
    else $error("convert phase too short");
  a_phase_excl: assert property ((sample_hold || converting) |-> busy
    && !(sample_hold && converting)) else $error("phase outside a busy conversion");
  a_chan_stable: assert property (converting |-> $stable(mux_pos) && $stable(mux_neg))
    else $error("channel moved during conversion");
  a_disabled_idle: assert property (!analog_en |=> !busy && !sample_hold)
    else $error("activity while disabled");
  // read data stand only in the cycle after a read strobe
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_mode_stable: assert property (converting |-> $stable(diff_mode))
    else $error("mode moved during conversion");
  // main scenarios reached
  c_start: cover property ($rose(busy));
  c_irq: cover property ($rose(irq_rdy));
  c_wcmp: cover property ($rose(irq_wcmp));
endmodule : sac_ctrl_props

bind sac_ctrl sac_ctrl_props u_props (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .ev_start(ev_start), .global_ie(global_ie),
  .sample_data(sample_data), .analog_en(analog_en), .sample_hold(sample_hold),
  .converting(converting), .diff_mode(diff_mode), .mux_pos(mux_pos), .mux_neg(mux_neg),
  .busy(busy), .irq_rdy(irq_rdy), .irq_wcmp(irq_wcmp));

/* File: bench/sac_analog_model.sv */
`timescale 1ns/1ps
module sac_analog_model (
  input wire logic clk,
  input wire logic analog_en,
  input wire logic sample_hold,
  input wire logic converting,
  input wire logic [11:0] level,
  output logic [11:0] sample_data
);
  logic tog_ff = 1'b0;
  // toggles so an idle core never looks like a held value
  always_ff @(posedge clk) tog_ff <= ~tog_ff;
  // powered core holds the level only while sampling or converting
  assign sample_data = (analog_en && (sample_hold || converting)) ? level :
                       (tog_ff ? ~level : 12'h5A5);
endmodule : sac_analog_model

/* File: bench/sac_ctrl_tb.sv */
`timescale 1ns/1ps
module sac_ctrl_tb import sac_pkg::*;;
  logic clk, rstn, wr, rd, ev_start, global_ie;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata;
  logic [11:0] level, sample_data;
  logic analog_en, sample_hold, converting, diff_mode, busy, irq_rdy, irq_wcmp;
  logic [4:0] mux_pos, mux_neg;
  int n_mismatch = 0;
  int total_checks = 0;
  int run_len = 0;
  int last_len = 0;
  // ctrla value, core level, expected result
  localparam logic [15:0] FMT_CA [6] = '{16'h0011, 16'h0009, 16'h0019,
                                         16'h0005, 16'h0005, 16'h0001};
  localparam logic [11:0] FMT_LV [6] = '{12'h123, 12'h123, 12'h123, 12'h800, 12'h7FF, 12'h800};
  localparam logic [15:0] FMT_EX [6] = '{16'h0048, 16'h1230, 16'h1200,
                                         16'hF800, 16'h07FF, 16'h0800};

  sac_ctrl uut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ev_start(ev_start), .global_ie(global_ie), .sample_data(sample_data),
    .analog_en(analog_en), .sample_hold(sample_hold), .converting(converting),
    .diff_mode(diff_mode), .mux_pos(mux_pos), .mux_neg(mux_neg), .busy(busy),
    .irq_rdy(irq_rdy), .irq_wcmp(irq_wcmp));
  sac_analog_model u_core (.clk(clk), .analog_en(analog_en), .sample_hold(sample_hold),
    .converting(converting), .level(level), .sample_data(sample_data));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // length of the last busy stretch, measured independently of the bus
  always @(posedge clk) begin
    if (busy === 1'b1) run_len <= run_len + 1;
    else if (run_len != 0) begin
      last_len <= run_len;
      run_len <= 0;
    end
  end

  // ****************************************
  // bus and compare helpers
  // ****************************************
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask : rd_reg
  task automatic chk(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wait_idle;
    int c;
    c = 0;
    #1;
    while (busy === 1'b1 && c < 20000) begin
      @(posedge clk);
      #1 c++;
    end
    if (c >= 20000) n_mismatch++;
    @(posedge clk);
  endtask : wait_idle
  task automatic conv(input string nm, input logic [DW-1:0] e);
    logic [DW-1:0] d;
    wr_reg(OFS_COMMAND, 16'h0001);
    wait_idle;
    rd_reg(OFS_RES, d);
    chk(nm, e, d);
  endtask : conv
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_single;
    logic [DW-1:0] d;
    rd_reg(4'hF, d);
    chk("unmapped", 16'h0000, d);
    wr_reg(OFS_CTRLB, 16'h0005);
    rd_reg(OFS_CTRLB, d);
    chk("ctrlb", 16'h0005, d);
    wr_reg(OFS_CTRLB, 16'h0000);
    wr_reg(OFS_THIRD_CONTROL_REGISTER, 16'h0000);
    wr_reg(OFS_MUX, 16'h0003);
    wr_reg(OFS_CTRLA, 16'h0001);
    wr_reg(OFS_COMMAND, 16'h0001);
    rd_reg(OFS_COMMAND, d);
    chk("busy_read", 16'h0001, d);
    wait_idle;
    rd_reg(OFS_INTERRUPT_FLAGS_REGISTER, d);
    chk("flag_polled", 16'h0001, d);
    chk("irq_off", 16'h0000, {15'h0000, irq_rdy});
    rd_reg(OFS_RES, d);
    chk("res12", 16'h0123, d);
    chk("conv_len", 16'h0022, last_len[15:0]);
    wr_reg(OFS_INTERRUPT_CONTROL_REGISTER, 16'h0001);
    chk("irq_noglobal", 16'h0000, {15'h0000, irq_rdy});
    global_ie <= 1'b1;
    @(posedge clk);
    #1 chk("irq_on", 16'h0001, {15'h0000, irq_rdy});
    wr_reg(OFS_INTERRUPT_FLAGS_REGISTER, 16'h0003);
    chk("irq_clear", 16'h0000, {15'h0000, irq_rdy});
    $display("test single done");
  endtask : t_single
  task automatic t_format;
    for (int i = 0; i < 6; i++) begin
      level <= FMT_LV[i];
      wr_reg(OFS_CTRLA, FMT_CA[i]);
      conv("format", FMT_EX[i]);
      chk("diff_mode", {15'h0000, FMT_CA[i][CA_CONVERSION_MODE_SELECT]}, {15'h0000, diff_mode});
    end
    level <= 12'h123;
    wr_reg(OFS_CTRLA, 16'h0001);
    wr_reg(OFS_CTRLB, 16'h0002);
    conv("acc4", 16'h048C);
    conv("acc4_again", 16'h048C);
    wr_reg(OFS_CTRLB, 16'h0007);
    conv("acc128", 16'h1230);
    wr_reg(OFS_CTRLB, 16'h0000);
    wr_reg(OFS_THIRD_CONTROL_REGISTER, 16'h0001);
    conv("clock_divider_select_res", 16'h0123);
    chk("clock_divider_select_len", 16'h0041, last_len[15:0]);
    conv("clock_divider_select_res2", 16'h0123);
    chk("clock_divider_select_len2", 16'h0041, last_len[15:0]);
    wr_reg(OFS_THIRD_CONTROL_REGISTER, 16'h0000);
    $display("test format done");
  endtask : t_format
  task automatic t_event;
    logic [DW-1:0] d;
    wr_reg(OFS_EVENT_CONTROL_REGISTER, 16'h0001);
    ev_start <= 1'b1;
    @(posedge clk);
    #1 chk("ev_busy", 16'h0001, {15'h0000, busy});
    wait_idle;
    repeat (40) @(posedge clk);
    chk("ev_level", 16'h0000, {15'h0000, busy});
    ev_start <= 1'b0;
    wr_reg(OFS_MUX, 16'h0203);
    wr_reg(OFS_CTRLA, 16'h0003);
    wr_reg(OFS_COMMAND, 16'h0001);
    wr_reg(OFS_MUX, 16'h0005);
    #1 chk("mux_hold", 16'h0003, {11'h000, mux_pos});
    chk("mux_neg_hold", 16'h0002, {11'h000, mux_neg});
    wr_reg(OFS_INTERRUPT_FLAGS_REGISTER, 16'h0003);
    d = '0;
    for (int i = 0; i < 40 && d[0] !== 1'b1; i++) rd_reg(OFS_INTERRUPT_FLAGS_REGISTER, d);
    chk("free_flag", 16'h0001, {15'h0000, d[0]});
    chk("free_busy", 16'h0001, {15'h0000, busy});
    chk("mux_new", 16'h0005, {11'h000, mux_pos});
    chk("mux_neg_new", 16'h0000, {11'h000, mux_neg});
    wr_reg(OFS_CTRLA, 16'h0001);
    wait_idle;
    wr_reg(OFS_EVENT_CONTROL_REGISTER, 16'h0000);
    ev_start <= 1'b1;
    repeat (3) @(posedge clk);
    chk("ev_off", 16'h0000, {15'h0000, busy});
    ev_start <= 1'b0;
    $display("test event done");
  endtask : t_event
  task automatic t_window;
    logic [DW-1:0] d;
    wr_reg(OFS_WINLT, 16'h0100);
    wr_reg(OFS_WINHT, 16'h0200);
    wr_reg(OFS_INTERRUPT_CONTROL_REGISTER, 16'h0002);
    for (int m = 1; m < 5; m++) begin
      wr_reg(OFS_WINCTRL, 16'(m));
      wr_reg(OFS_INTERRUPT_FLAGS_REGISTER, 16'h0003);
      conv("win_res", 16'h0123);
      rd_reg(OFS_INTERRUPT_FLAGS_REGISTER, d);
      chk("win_flag", {15'h0000, m == 3}, {15'h0000, d[1]});
      chk("win_irq", {15'h0000, m == 3}, {15'h0000, irq_wcmp});
    end
    wr_reg(OFS_CTRLA, 16'h0000);
    wr_reg(OFS_INTERRUPT_FLAGS_REGISTER, 16'h0003);
    wr_reg(OFS_COMMAND, 16'h0001);
    repeat (40) @(posedge clk);
    rd_reg(OFS_INTERRUPT_FLAGS_REGISTER, d);
    chk("off_flag", 16'h0000, d);
    chk("off_busy", 16'h0000, {15'h0000, busy});
    $display("test window done");
  endtask : t_window

  initial begin
    rstn = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    ev_start = 1'b0;
    global_ie = 1'b0;
    level = 12'h123;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_single;
    t_format;
    t_event;
    t_window;
    results;
  end
  // hang guard: the whole run needs about 5300 cycles
  initial begin
    #(40 * 30000);
    n_mismatch++;
    results;
  end
endmodule : sac_ctrl_tb
